// file: smc_regs.vh
// Register map, field positions and timing constants of the standby mode controller.
// Assumes a 125 MHz mclk; included by bare name from the AXI front end, the top and the bench.
`ifndef SMC_REGS_VH
`define SMC_REGS_VH
// Stabilization time select register: printed at 0xFFF4, byte address kept as printed
`define SMC_STAB_SEL_ADDR 16'hFFF4
// Control register with clock source select, watchdog clock source and option readback
`define SMC_CTRL_ADDR 16'hFFF8
// Read-only status of the controller
`define SMC_STATUS_ADDR 16'hFFFC
// Low-speed oscillator mode register, bit 0 is the software stop bit
`define SMC_LSO_MODE_ADDR 16'hFFF0
`define SMC_LSO_STOP_BIT 0
`define SMC_STAB_SEL_W 2
// Select register value after reset; undefined in hardware, longest wait picked here
`define SMC_STAB_SEL_RST 2'h3
// Status register bit that mirrors the low-speed oscillator enable
`define SMC_STATUS_LSO_BIT 8
// Control register fields
`define SMC_CTRL_CLKSRC_BIT 0
`define SMC_CTRL_WDT_LSO_BIT 1
`define SMC_CTRL_LSO_SWSTOP_OK_BIT 2
// Operation stop time after stop release, in ns (min/typ/max)
`define SMC_STOP_TIME_MIN_NS 17000
`define SMC_STOP_TIME_TYP_NS 34000
`define SMC_STOP_TIME_MAX_NS 67000
`define SMC_CLK_PERIOD_NS 8
// Typical stop time in mclk cycles, rounded down as a nominal figure
`define SMC_STOP_TIME_CYC (`SMC_STOP_TIME_TYP_NS / `SMC_CLK_PERIOD_NS)
// Stabilization wait exponents for codes 00, 01, 10, 11
`define SMC_STAB_EXP0 10
`define SMC_STAB_EXP1 12
`define SMC_STAB_EXP2 15
`define SMC_STAB_EXP3 17
`define SMC_CNT_W 18
`endif

// file: smc_axil.v
// AXI4-Lite slave front end: takes one write and one read, hands simple strobes on.
// Assumes the core answers reads combinationally from rd_addr in the same cycle.
`include "smc_regs.vh"
module smc_axil (
   input wire mclk, // System clock
   input wire rst, // Asynchronous reset, active high
   input wire [15:0] s_axi_awaddr, // Write address
   input wire s_axi_awvalid, // Write address valid
   output wire s_axi_awready, // Write address ready
   input wire [31:0] s_axi_wdata, // Write data
   input wire [3:0] s_axi_wstrb, // Write strobes
   input wire s_axi_wvalid, // Write data valid
   output wire s_axi_wready, // Write data ready
   output reg [1:0] s_axi_bresp, // Write response
   output reg s_axi_bvalid, // Write response valid
   input wire s_axi_bready, // Write response ready
   input wire [15:0] s_axi_araddr, // Read address
   input wire s_axi_arvalid, // Read address valid
   output wire s_axi_arready, // Read address ready
   output reg [31:0] s_axi_rdata, // Read data
   output reg [1:0] s_axi_rresp, // Read response
   output reg s_axi_rvalid, // Read data valid
   input wire s_axi_rready, // Read data ready
   output wire wr_en, // One-cycle write strobe to core
   output reg [15:0] wr_addr, // Write address to core
   output reg [31:0] wr_data, // Write data to core
   output reg [3:0] wr_strb, // Write byte enables to core
   input wire wr_ok, // Core decodes wr_addr
   output wire [15:0] rd_addr, // Read address to core
   input wire [31:0] rd_data, // Read data from core
   input wire rd_ok // Core decodes rd_addr
);
   reg aw_have_q;
   reg w_have_q;
   // Each channel is taken independently; a held half waits for its partner
   assign s_axi_awready = ~aw_have_q & ~s_axi_bvalid;
   assign s_axi_wready = ~w_have_q & ~s_axi_bvalid;
   assign s_axi_arready = ~s_axi_rvalid;
   assign rd_addr = s_axi_araddr;
   assign wr_en = aw_have_q & w_have_q & ~s_axi_bvalid;
   // Write capture and response
   always @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         wr_addr <= 16'h0000;
         wr_data <= 32'h00000000;
         wr_strb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_have_q <= 1'b1;
            wr_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_have_q <= 1'b1;
            wr_data <= s_axi_wdata;
            wr_strb <= s_axi_wstrb;
         end
         if (wr_en)
         begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? 2'h0 : 2'h2; // SLVERR on unmapped address
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end
   // Read answer one cycle after the address is taken
   always @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= 2'h0;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_ok ? rd_data : 32'h00000000;
         s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
      end
      else if (s_axi_rvalid && s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end
endmodule

// file: smc_wait_cnt.v
// Down counter used for the operation stop time and the stabilization wait.
// Assumes load and run come from logic on mclk.
module smc_wait_cnt #(
   parameter W = 18 // Counter width
) (
   input wire mclk, // System clock
   input wire rst, // Asynchronous reset, active high
   input wire load, // Load a new count
   input wire [W-1:0] load_val, // Cycles to count
   input wire run, // Count while high
   output wire done // High when count reached zero
);
   reg [W-1:0] cnt_q;
   // Load wins over counting so a fresh wait never inherits an old remainder
   always @(posedge mclk or posedge rst)
   begin
      if (rst)
         cnt_q <= {W{1'b0}};
      else if (load)
         cnt_q <= load_val;
      else if (run && cnt_q != {W{1'b0}})
         cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
   end
   assign done = (cnt_q == {W{1'b0}});
endmodule

// file: smc_top.v
// Standby mode controller: halt and stop modes, clock gating and wake-up waits.
// Assumes the CPU pulses halt_req/stop_req on mclk and the oscillator reports osc_started.
// Notes on behaviour
// [R1] Halt instruction gates the CPU clock
// [R2] Halt keeps system oscillator and peripheral clock
// [R3] Running low-speed oscillator keeps running in halt
// [R4] Stop instruction halts system oscillator
// [R5] Interrupt request releases stop mode
// [R6] Hold operation for stop time after release
// [R7] Standby keeps registers, flags, latches unchanged
// [R8] Stabilization wait only for crystal/ceramic source
// [R9] No wait for internal or external clock
// [R10] Codes select 2^10, 2^12, 2^15, 2^17 cycles
// [R11] Select register at FFF4, bits 7:2 zero
// [R12] Count wait only from oscillation start
// [R13] Software stop bit honoured only when option allows
// [R14] Running low-speed oscillator not stopped in stop
// [R15] Stop low-speed watchdog clock in stop mode
// [R16] Software stops peripherals before stop instruction
// [R17] Software clears converter bits before standby
// [R18] Software programs long enough stabilization time
// [R19] Pending unmasked interrupt releases standby immediately
// [R20] Wait counter re-enables CPU clock at terminal count
//
// The implementer's own choice: register access over AXI4-Lite.
`include "smc_regs.vh"
module smc_top #(
   parameter STOP_CYC = `SMC_STOP_TIME_CYC, // Operation stop time in cycles
   parameter STAB_EXP0 = `SMC_STAB_EXP0, // Wait exponent, code 00
   parameter STAB_EXP1 = `SMC_STAB_EXP1, // Wait exponent, code 01
   parameter STAB_EXP2 = `SMC_STAB_EXP2, // Wait exponent, code 10
   parameter STAB_EXP3 = `SMC_STAB_EXP3 // Wait exponent, code 11
) (
   input wire mclk, // System clock, 125 MHz
   input wire rst, // Asynchronous reset, active high
   input wire [15:0] s_axi_awaddr, // AXI write address
   input wire s_axi_awvalid, // AXI write address valid
   output wire s_axi_awready, // AXI write address ready
   input wire [31:0] s_axi_wdata, // AXI write data
   input wire [3:0] s_axi_wstrb, // AXI write strobes
   input wire s_axi_wvalid, // AXI write data valid
   output wire s_axi_wready, // AXI write data ready
   output wire [1:0] s_axi_bresp, // AXI write response
   output wire s_axi_bvalid, // AXI write response valid
   input wire s_axi_bready, // AXI write response ready
   input wire [15:0] s_axi_araddr, // AXI read address
   input wire s_axi_arvalid, // AXI read address valid
   output wire s_axi_arready, // AXI read address ready
   output wire [31:0] s_axi_rdata, // AXI read data
   output wire [1:0] s_axi_rresp, // AXI read response
   output wire s_axi_rvalid, // AXI read valid
   input wire s_axi_rready, // AXI read ready
   input wire halt_req, // CPU executed halt, one-cycle pulse
   input wire stop_req, // CPU executed stop, one-cycle pulse
   input wire irq_pending, // Some request flag set with mask clear
   input wire osc_started, // System oscillator running again (pin)
   input wire lso_sw_stop_allowed, // Option: low-speed osc stoppable by software
   output reg cpu_clk_en, // CPU clock gate enable
   output reg periph_clk_en, // Peripheral clock gate enable
   output reg sys_osc_en, // System oscillator enable
   output reg lso_en, // Low-speed oscillator enable
   output reg wdt_lso_clk_en, // Watchdog clock enable when on low-speed osc
   output reg hold_state // Freeze request for registers, latches and buffers
);
   // One-hot controller states
   localparam [4:0] ST_RUN = 5'h01;
   localparam [4:0] ST_HALT = 5'h02;
   localparam [4:0] ST_STOP = 5'h04;
   localparam [4:0] ST_OSC = 5'h08;
   localparam [4:0] ST_WAIT = 5'h10;
   localparam CW = `SMC_CNT_W;

   wire wr_en;
   wire [15:0] wr_addr;
   wire [31:0] wr_data;
   wire [3:0] wr_strb;
   wire [15:0] rd_addr;
   reg [31:0] rd_data;
   reg rd_ok;
   reg wr_ok;
   reg [4:0] state_q;
   reg [4:0] state_d;
   reg [1:0] stab_sel_q;
   reg clk_src_xtal_q;
   reg wdt_on_lso_q;
   reg low_speed_osc_sw_stop_q;
   reg osc_s1_q;
   reg osc_s2_q;
   reg opt_s1_q;
   reg opt_s2_q;
   reg cnt_load;
   reg [CW-1:0] cnt_val;
   reg cnt_run;
   wire cnt_done;

   // Wait length for a stabilization code
   function [CW-1:0] stab_cycles;
      input [1:0] code;
      begin
         case (code)
            2'h0: stab_cycles = {{(CW-1){1'b0}}, 1'b1} << STAB_EXP0; // R10
            2'h1: stab_cycles = {{(CW-1){1'b0}}, 1'b1} << STAB_EXP1; // R10
            2'h2: stab_cycles = {{(CW-1){1'b0}}, 1'b1} << STAB_EXP2; // R10
            default: stab_cycles = {{(CW-1){1'b0}}, 1'b1} << STAB_EXP3; // R10
         endcase
      end
   endfunction

   smc_axil u_axil (
      .mclk(mclk),
      .rst(rst),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .wr_en(wr_en),
      .wr_addr(wr_addr),
      .wr_data(wr_data),
      .wr_strb(wr_strb),
      .wr_ok(wr_ok),
      .rd_addr(rd_addr),
      .rd_data(rd_data),
      .rd_ok(rd_ok)
   );

   smc_wait_cnt #(
      .W(CW)
   ) u_cnt (
      .mclk(mclk),
      .rst(rst),
      .load(cnt_load),
      .load_val(cnt_val),
      .run(cnt_run),
      .done(cnt_done)
   );

   // Oscillator-start flag and option strap come from outside the clock domain
   always @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         osc_s1_q <= 1'b0;
         osc_s2_q <= 1'b0;
         opt_s1_q <= 1'b0;
         opt_s2_q <= 1'b0;
      end
      else
      begin
         osc_s1_q <= osc_started;
         osc_s2_q <= osc_s1_q;
         opt_s1_q <= lso_sw_stop_allowed;
         opt_s2_q <= opt_s1_q;
      end
   end

   // Address decode for writes
   always @*
   begin
      if (wr_addr == `SMC_STAB_SEL_ADDR)
         wr_ok = 1'b1;
      else if (wr_addr == `SMC_CTRL_ADDR)
         wr_ok = 1'b1;
      else if (wr_addr == `SMC_LSO_MODE_ADDR)
         wr_ok = 1'b1;
      else if (wr_addr == `SMC_STATUS_ADDR)
         wr_ok = 1'b1;
      else
         wr_ok = 1'b0;
   end

   // Register writes; status writes are accepted and ignored
   always @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         stab_sel_q <= `SMC_STAB_SEL_RST; // Longest wait is the safe pick
         clk_src_xtal_q <= 1'b1;
         wdt_on_lso_q <= 1'b0;
         low_speed_osc_sw_stop_q <= 1'b0;
      end
      else if (wr_en && wr_strb[0])
      begin
         if (wr_addr == `SMC_STAB_SEL_ADDR)
            stab_sel_q <= wr_data[`SMC_STAB_SEL_W-1:0]; // R11
         else if (wr_addr == `SMC_CTRL_ADDR)
         begin
            clk_src_xtal_q <= wr_data[`SMC_CTRL_CLKSRC_BIT];
            wdt_on_lso_q <= wr_data[`SMC_CTRL_WDT_LSO_BIT];
         end
         else if (wr_addr == `SMC_LSO_MODE_ADDR)
            low_speed_osc_sw_stop_q <= wr_data[`SMC_LSO_STOP_BIT];
      end
   end

   // Read decode, upper bits read as zero
   always @*
   begin
      rd_data = 32'h00000000;
      rd_ok = 1'b1;
      if (rd_addr == `SMC_STAB_SEL_ADDR)
         rd_data[1:0] = stab_sel_q; // R11
      else if (rd_addr == `SMC_CTRL_ADDR)
      begin
         rd_data[`SMC_CTRL_CLKSRC_BIT] = clk_src_xtal_q;
         rd_data[`SMC_CTRL_WDT_LSO_BIT] = wdt_on_lso_q;
         rd_data[`SMC_CTRL_LSO_SWSTOP_OK_BIT] = opt_s2_q;
      end
      else if (rd_addr == `SMC_LSO_MODE_ADDR)
         rd_data[`SMC_LSO_STOP_BIT] = low_speed_osc_sw_stop_q;
      else if (rd_addr == `SMC_STATUS_ADDR)
      begin
         rd_data[4:0] = state_q;
         rd_data[`SMC_STATUS_LSO_BIT] = lso_en;
      end
      else
         rd_ok = 1'b0;
   end

   // Mode sequencing; a pending interrupt blocks entry, so the state stays in run
   always @*
   begin
      state_d = state_q;
      cnt_load = 1'b0;
      cnt_val = {CW{1'b0}};
      cnt_run = 1'b0;
      case (state_q)
         ST_RUN:
         begin
            if (stop_req && !irq_pending) // R19
               state_d = ST_STOP; // R4
            else if (halt_req && !irq_pending) // R19
               state_d = ST_HALT; // R1
         end
         ST_HALT:
         begin
            if (irq_pending) // R19
               state_d = ST_RUN;
         end
         ST_STOP:
         begin
            if (irq_pending) // R5
            begin
               state_d = ST_OSC;
               cnt_load = 1'b1;
               cnt_val = STOP_CYC[CW-1:0]; // R6
            end
         end
         ST_OSC:
         begin
            // Stop time runs first; the wait only starts once the oscillator is up
            cnt_run = 1'b1; // R6
            if (cnt_done && osc_s2_q) // R12
            begin
               if (clk_src_xtal_q) // R8
               begin
                  state_d = ST_WAIT;
                  cnt_load = 1'b1;
                  cnt_val = stab_cycles(stab_sel_q); // R10
               end
               else
                  state_d = ST_RUN; // R9
            end
         end
         ST_WAIT:
         begin
            cnt_run = 1'b1; // R20
            if (cnt_done)
               state_d = ST_RUN; // R20
         end
         default:
            state_d = ST_RUN;
      endcase
   end

   // State register
   always @(posedge mclk or posedge rst)
   begin
      if (rst)
         state_q <= ST_RUN;
      else
         state_q <= state_d;
   end

   // Clock and oscillator controls, registered from the next state
   always @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         cpu_clk_en <= 1'b1;
         periph_clk_en <= 1'b1;
         sys_osc_en <= 1'b1;
         lso_en <= 1'b1;
         wdt_lso_clk_en <= 1'b1;
         hold_state <= 1'b0;
      end
      else
      begin
         cpu_clk_en <= (state_d == ST_RUN); // R1 R20
         periph_clk_en <= (state_d == ST_RUN) || (state_d == ST_HALT); // R2
         sys_osc_en <= (state_d != ST_STOP); // R2 R4
         hold_state <= (state_d != ST_RUN); // R7
         // Software stop acts only outside standby, so a running osc stays up there
         if (state_d == ST_RUN)
            lso_en <= ~(opt_s2_q & low_speed_osc_sw_stop_q); // R13
         else
            lso_en <= lso_en; // R3 R14
         wdt_lso_clk_en <= ~(wdt_on_lso_q && (state_d != ST_RUN)
            && (state_d != ST_HALT)); // R15
      end
   end
endmodule

// file: smc_properties.sv
// Concurrent checks on the standby mode controller top ports.
// Assumes one mclk domain with asynchronous active-high rst; bound below.
module smc_properties #(
   parameter STOP_CYC = 8 // Operation stop time in cycles
) (
   input logic mclk, // Clock
   input logic rst, // Reset
   input logic halt_req, // Halt pulse
   input logic stop_req, // Stop pulse
   input logic irq_pending, // Unmasked request
   input logic cpu_clk_en, // CPU clock gate
   input logic periph_clk_en, // Peripheral clock gate
   input logic sys_osc_en, // System oscillator enable
   input logic lso_en, // Low-speed oscillator enable
   input logic wdt_lso_clk_en, // Watchdog clock gate
   input logic hold_state // Freeze request
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge mclk);
   endclocking
   default disable iff (rst);
   logic stop_seen_q;
   logic [15:0] wake_cnt_q;
   // Cycles since the oscillator enable came back; the flag keeps halt wake-ups out
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         stop_seen_q <= 1'b0;
         wake_cnt_q <= 16'h0000;
      end
      else
      begin
         stop_seen_q <= !sys_osc_en || (stop_seen_q && !cpu_clk_en);
         wake_cnt_q <= sys_osc_en ? wake_cnt_q + 16'h0001 : 16'h0000;
      end
   end
   sequence s_halted;
      hold_state && !cpu_clk_en && periph_clk_en;
   endsequence
   sequence s_run_req(req);
      req && !irq_pending && !hold_state;
   endsequence
   halt_gate_a: assert property (
      s_run_req(halt_req && !stop_req) |=> !cpu_clk_en && periph_clk_en && sys_osc_en)
      else $error("halt entry clocks wrong");
   stop_enter_a: assert property (
      s_run_req(stop_req) |=> !sys_osc_en && !cpu_clk_en && hold_state)
      else $error("stop entry wrong");
   stop_stays_a: assert property (
      !sys_osc_en && !irq_pending |=> !sys_osc_en)
      else $error("stop left without request");
   stop_release_a: assert property (
      !sys_osc_en && irq_pending |=> sys_osc_en)
      else $error("stop not released");
   halt_release_a: assert property (
      s_halted ##0 irq_pending |=> cpu_clk_en)
      else $error("halt not released");
   stop_time_a: assert property (
      stop_seen_q && $rose(cpu_clk_en) |-> wake_cnt_q >= STOP_CYC)
      else $error("stop time too short");
   lso_keep_a: assert property (
      hold_state && lso_en ##1 hold_state |-> lso_en)
      else $error("low-speed osc stopped in standby");
   wdt_gate_a: assert property (
      !wdt_lso_clk_en |-> hold_state && !periph_clk_en)
      else $error("watchdog clock gated outside stop");
   irq_block_a: assert property (
      (halt_req || stop_req) && irq_pending && !hold_state |=> cpu_clk_en)
      else $error("standby entered with request pending");
endmodule

bind smc_top smc_properties #(.STOP_CYC(STOP_CYC)) i_props (.*);

// file: smc_osc_model.sv
// System oscillator model facing the controller's oscillator enable.
// Assumes the bench sets start_dly before each stop.
module smc_osc_model (
   input logic mclk, // Clock
   input logic rst, // Reset
   input logic sys_osc_en, // Oscillator enable
   input int start_dly, // Cycles until oscillation
   output logic osc_started // Oscillation running
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt_q;
   // Start-up is slow on purpose, so a wait counted from release shows up short
   always @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         cnt_q <= 0;
         osc_started <= 1'b1;
      end
      else if (!sys_osc_en)
      begin
         cnt_q <= 0;
         osc_started <= 1'b0;
      end
      else if (cnt_q >= start_dly)
         osc_started <= 1'b1;
      else
         cnt_q <= cnt_q + 1;
   end
endmodule

// file: test_standby_mode_controller.sv
// Bench for the standby mode controller: AXI4-Lite tasks and mode pulses.
// Assumes shortened stop time and wait exponents 2 to 5 on the instance.
`include "smc_regs.vh"
module test_standby_mode_controller;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int STOP = 8;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic [15:0] s_axi_awaddr = 16'h0000, s_axi_araddr = 16'h0000;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic halt_req = 1'b0, stop_req = 1'b0, irq_pending = 1'b0, lso_sw_stop_allowed = 1'b0;
   logic osc_started, cpu_clk_en, periph_clk_en, sys_osc_en, lso_en;
   logic wdt_lso_clk_en, hold_state;
   int osc_dly = 1;
   int err_count = 0;
   int n_compared = 0;
   int n;
   int m;
   smc_top #(.STOP_CYC(STOP), .STAB_EXP0(2), .STAB_EXP1(3), .STAB_EXP2(4), .STAB_EXP3(5))
      i_dut (.*);
   smc_osc_model i_osc (.mclk(mclk), .rst(rst), .sys_osc_en(sys_osc_en),
      .start_dly(osc_dly), .osc_started(osc_started));
   always #4 mclk = ~mclk;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         err_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_rng(input int v, input int lo, input int hi);
      n_compared++;
      if (v < lo || v > hi)
      begin
         err_count++;
         $display("[ERR] %0t %0d cycles, expected %0d..%0d", $time, v, lo, hi);
      end
   endtask
   // Both halves offered together, each dropped once taken
   task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw;
      logic w;
      @(posedge mclk);
      aw = 1'b1;
      w = 1'b1;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (aw || w)
      begin
         @(posedge mclk);
         if (aw && s_axi_awready === 1'b1)
         begin
            aw = 1'b0;
            s_axi_awvalid <= 1'b0;
         end
         if (w && s_axi_wready === 1'b1)
         begin
            w = 1'b0;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge mclk); while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      chk(s_axi_bresp, er);
   endtask
   task automatic rd(input logic [15:0] a, input logic [31:0] ed, input logic [1:0] er);
      @(posedge mclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge mclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge mclk); while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      chk(s_axi_rdata, ed);
      chk(s_axi_rresp, er);
   endtask
   // One-cycle mode pulse; returns at the following falling edge
   task automatic pulse(input logic stop);
      @(posedge mclk);
      halt_req <= !stop;
      stop_req <= stop;
      @(posedge mclk);
      halt_req <= 1'b0;
      stop_req <= 1'b0;
      @(negedge mclk);
   endtask
   // Raise a request and count edges until the CPU clock returns
   task automatic wake(output int c, output int o);
      c = 0;
      o = -1;
      @(posedge mclk);
      irq_pending <= 1'b1;
      do
      begin
         @(posedge mclk);
         c++;
         if (o < 0 && osc_started === 1'b1)
            o = c;
      end
      while (cpu_clk_en !== 1'b1);
      irq_pending <= 1'b0;
   endtask
   task automatic stop_run(input logic [31:0] ctrl, input logic [1:0] code, input int dly);
      int c;
      int o;
      wr(`SMC_STAB_SEL_ADDR, {30'h0, code}, 2'h0);
      wr(`SMC_CTRL_ADDR, ctrl, 2'h0);
      osc_dly <= dly;
      pulse(1'b1);
      chk(sys_osc_en | cpu_clk_en | periph_clk_en, 1'b0);
      chk(lso_en & hold_state, 1'b1);
      chk(wdt_lso_clk_en, !ctrl[1]);
      rd(`SMC_STATUS_ADDR, 32'h104, 2'h0);
      wake(c, o);
      if (ctrl[0])
         chk_rng(c - o, (1 << (code + 2)) + 3, (1 << (code + 2)) + 6);
      else
         chk_rng(c, STOP + 1, STOP + 4);
      $display("stop test done, code %0d", code);
   endtask
   task automatic end_sim;
      $display("compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial
   begin
      repeat (4) @(posedge mclk);
      rst <= 1'b0;
      rd(`SMC_STAB_SEL_ADDR, 32'h3, 2'h0);
      rd(`SMC_CTRL_ADDR, 32'h1, 2'h0);
      rd(`SMC_STATUS_ADDR, 32'h101, 2'h0);
      wr(`SMC_STAB_SEL_ADDR, 32'hFF, 2'h0);
      rd(`SMC_STAB_SEL_ADDR, 32'h3, 2'h0);
      wr(16'hFFE0, 32'h1, 2'h2);
      rd(16'hFFE0, 32'h0, 2'h2);
      $display("register test done");
      pulse(1'b0);
      chk(cpu_clk_en, 1'b0);
      chk(periph_clk_en & sys_osc_en & lso_en, 1'b1);
      rd(`SMC_STATUS_ADDR, 32'h102, 2'h0);
      wake(n, m);
      chk_rng(n, 1, 2);
      @(posedge mclk);
      irq_pending <= 1'b1;
      pulse(1'b1);
      chk(cpu_clk_en & sys_osc_en, 1'b1);
      pulse(1'b0);
      chk(cpu_clk_en, 1'b1);
      @(posedge mclk);
      irq_pending <= 1'b0;
      $display("halt test done");
      for (int c = 0; c < 4; c++)
         stop_run(32'h1, c[1:0], 20);
      stop_run(32'h0, 2'h3, 1);
      stop_run(32'h3, 2'h0, 20);
      wr(`SMC_LSO_MODE_ADDR, 32'h1, 2'h0);
      repeat (4) @(posedge mclk);
      chk(lso_en, 1'b1);
      lso_sw_stop_allowed <= 1'b1;
      repeat (4) @(posedge mclk);
      chk(lso_en, 1'b0);
      rd(`SMC_CTRL_ADDR, 32'h7, 2'h0);
      pulse(1'b0);
      chk(lso_en, 1'b0);
      wake(n, m);
      wr(`SMC_LSO_MODE_ADDR, 32'h0, 2'h0);
      repeat (4) @(posedge mclk);
      chk(lso_en, 1'b1);
      $display("low-speed test done");
      end_sim;
   end
   // Runs take a few hundred cycles; this cuts a hang short
   initial
   begin
      repeat (20000) @(posedge mclk);
      err_count++;
      $display("[ERR] %0t watchdog expired", $time);
      end_sim;
   end
endmodule
